// ==== logic/ident_dc_pkg.sv ====
/*
  Constants for the stereo identification and carrier DC readout block:
  word addresses, identification codes, reset values and sample-rate time constants.
  Assumes the audio samples arrive at one fixed sample rate, strobed by valid pulses.
*/
// What this block does
// - Ident mode is low byte of word 0x15; 0x00 German, 0x01 Korean, reset 0x00.
// - Writing 0x3F to the ident mode clears the identification filter.
// - Standard selection loads ident mode; auto sound select keeps updating it.
// - Every readable register is a full 16-bit word on each transfer.
// - Words 0x15 and 0x18 decode only one byte; the other byte reads as zero.
// - Read-only registers ignore host writes.
// - Stereo detection level is signed high byte of word 0x18.
// - Carrier one DC level at word 0x1B, carrier two at 0x1C.
// - DC levels are signed 16-bit values from 0x8000 to 0x7FFF.
// - DC level positive when oscillator is below carrier, negative otherwise.
// - DC level smoothing time constant is roughly 28 ms; the filter uses 2048 samples, about 43 ms.
// - DC component is removed from audio yet kept in the DC registers.
// - Terrestrial manual mode: select 0 is FM/AM, select 1 is stereo/AB.
// - Satellite: select 3 gives stereo or carrier one, select 4 stereo or two.
// - Digital sound missing: stereo/AB silent, or analog mono with FM fallback.
// - Digital standards force FM matrix to sound-A mono; host writes nothing else.
// - Main, aux and line two share polarity; line one is inverted.

`default_nettype none

package ident_dc_pkg;

  // ----------------------------------------
  // Word addresses
  // ----------------------------------------
  localparam logic [15:0] ADDR_IDENT_MODE = 16'h0015;
  localparam logic [15:0] ADDR_STEREO_DETECT = 16'h0018;
  localparam logic [15:0] ADDR_DC_ONE = 16'h001B;
  localparam logic [15:0] ADDR_DC_TWO = 16'h001C;

  // ----------------------------------------
  // Identification mode codes
  // ----------------------------------------
  localparam logic [7:0] IDENT_GERMAN = 8'h00;
  localparam logic [7:0] IDENT_KOREAN = 8'h01;
  localparam logic [7:0] IDENT_FILTER_CLEAR = 8'h3F;
  localparam logic [7:0] IDENT_MODE_RESET = 8'h00;

  // ----------------------------------------
  // Channel select codes
  // ----------------------------------------
  localparam logic [2:0] SEL_FMAM = 3'h0;
  localparam logic [2:0] SEL_STEREO_AB = 3'h1;
  localparam logic [2:0] SEL_STEREO_OR_ONE = 3'h3;
  localparam logic [2:0] SEL_STEREO_OR_TWO = 3'h4;

  // ----------------------------------------
  // Timing, in audio samples
  // ----------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int SAMPLE_HZ = 48000;
  localparam int DC_TAU_MS = 28;
  localparam int DC_TAU_SAMPLES = DC_TAU_MS * SAMPLE_HZ / 1000;
  // Next power of two up keeps the filter a shift, not a multiply
  localparam int DC_SHIFT = $clog2(DC_TAU_SAMPLES);
  localparam int IDENT_TAU_MS = 100;
  localparam int IDENT_TAU_SAMPLES = IDENT_TAU_MS * SAMPLE_HZ / 1000;
  localparam int IDENT_SHIFT = $clog2(IDENT_TAU_SAMPLES);

  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] AUDIO_MAX = 16'h7FFF;
  localparam logic [15:0] AUDIO_MIN = 16'h8000;

endpackage

`default_nettype wire

// ==== logic/dc_track_if.sv ====
/*
  Carrier between the register block and one DC tracker: the carrier sample in,
  its DC level and DC-free audio out. Assumes both ends run on clk_sys.
*/
`default_nettype none

interface dc_track_if;
  logic sample_valid;
  logic [15:0] sample;
  logic [15:0] dc_level;
  logic [15:0] audio;

  modport tracker (input sample_valid, input sample, output dc_level, output audio);
  modport owner (output sample_valid, output sample, input dc_level, input audio);
endinterface

`default_nettype wire

// ==== logic/dc_tracker.sv ====
/*
  One-pole DC estimator for one FM carrier, plus removal of that DC from the audio.
  Assumes samples arrive on sample_valid pulses on clk_sys, already signed as the
  demodulator gives them: positive when the carrier is above the oscillator.
*/
`default_nettype none

module dc_tracker (
  input wire logic clk_sys,            // System clock
  input wire logic rst_b,              // Asynchronous reset, active low
  input wire logic ce,                 // Clock enable
  dc_track_if.tracker trk              // Sample in, level and audio out
);

  localparam int AW = 16 + ident_dc_pkg::DC_SHIFT + 1;

  logic signed [AW-1:0] acc_ff;
  logic signed [15:0] dc_ff;
  logic [15:0] audio_ff;
  logic signed [AW-1:0] nxt_acc;
  logic signed [16:0] nxt_diff;

  // ----------------------------------------
  // Leaky integrator
  // ----------------------------------------
  // acc holds dc scaled by 2^shift, so dc always stays within the 16-bit range
  always_comb begin
    nxt_acc = acc_ff + AW'($signed(trk.sample)) - (acc_ff >>> ident_dc_pkg::DC_SHIFT);
    nxt_diff = 17'($signed(trk.sample)) - 17'(dc_ff);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_ff <= '0;
      dc_ff <= '0;
    end else if (ce && trk.sample_valid) begin
      acc_ff <= nxt_acc;
      dc_ff <= 16'(nxt_acc >>> ident_dc_pkg::DC_SHIFT);
    end
  end

  // ----------------------------------------
  // DC-free audio, saturated to 16 bits
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      audio_ff <= ident_dc_pkg::WORD_ZERO;
    end else if (ce && trk.sample_valid) begin
      if (nxt_diff[16] != nxt_diff[15]) begin
        audio_ff <= nxt_diff[16] ? ident_dc_pkg::AUDIO_MIN : ident_dc_pkg::AUDIO_MAX;
      end else begin
        audio_ff <= nxt_diff[15:0];
      end
    end
  end

  assign trk.dc_level = dc_ff;
  assign trk.audio = audio_ff;

endmodule

`default_nettype wire

// ==== logic/stereo_ident_dc_regs.sv ====
/*
  Stereo identification mode register, identification filter, carrier DC readouts,
  source channel routing and output polarity for the demodulator readout section.
  Assumes the serial host interface delivers whole 16-bit word accesses on clk_sys,
  and that all audio and ident samples come from logic on the same clock.
*/
`default_nettype none

module stereo_ident_dc_regs (
  input wire logic clk_sys,                    // System clock, 25 MHz
  input wire logic rst_b,                      // Asynchronous reset, active low
  input wire logic ce,                         // Clock enable, freezes all state when low
  // Word access from the serial host interface
  input wire logic [15:0] reg_addr,            // Word address
  input wire logic [15:0] reg_wdata,           // Write word
  input wire logic reg_wr,                     // Write strobe, one cycle
  input wire logic reg_rd,                     // Read strobe, one cycle
  output logic [15:0] reg_rdata,               // Read word
  output logic reg_rvalid,                     // Read word valid, one cycle
  // Standard selection and automatic sound select
  input wire logic std_load,                   // Standard selected, one cycle
  input wire logic [7:0] std_ident_code,       // Ident mode for selected standard
  input wire logic auto_sound_select,          // Automatic sound select enabled
  input wire logic [7:0] auto_ident_code,      // Ident mode chosen by automatic select
  // Identification pilot measurement
  input wire logic ident_valid,                // Ident sample strobe
  input wire logic [7:0] ident_sample,         // Signed pilot level for current mode
  output logic ident_korean,                   // Korean pilot detection selected
  output logic ident_active,                   // Identification running
  // FM carriers
  input wire logic [1:0] fm_valid,             // Sample strobes, carrier one in bit 0
  input wire logic [1:0][15:0] fm_sample,      // Signed demodulated carriers
  output logic [1:0][15:0] carrier_audio,      // DC-free carrier audio
  // Source routing
  input wire logic [2:0] chan_select,          // Demodulator source select
  input wire logic sat_std,                    // Satellite FM standard selected
  input wire logic stereo_mode,                // Broadcast carries stereo
  input wire logic digital_std,                // Digital-sound standard selected
  input wire logic digital_ok,                 // Digital sound present and clean
  input wire logic digital_sound_fm_fallback,  // FM fallback enabled
  input wire logic [1:0][15:0] fmam_in,        // FM/AM path, left in 0
  input wire logic [1:0][15:0] stereo_ab_in,   // Stereo or A/B path, left in 0
  input wire logic [15:0] analog_mono,         // Analog mono
  output logic fm_matrix_sound_a,              // FM matrix forced to sound-A mono
  output logic [1:0][15:0] main_out,           // Main output, left in 0
  output logic [1:0][15:0] aux_out,            // Aux output, left in 0
  output logic [1:0][15:0] line_output_one,    // Line output one, inverted
  output logic [1:0][15:0] line_output_two     // Line output two
);

  logic [7:0] ident_mode_ff;
  logic signed [15:0] ident_acc_ff;
  logic [15:0] rdata_ff;
  logic rvalid_ff;
  logic korean_ff;
  logic active_ff;
  logic matrix_ff;
  logic [1:0][15:0] routed;
  logic [1:0][15:0] main_ff;
  logic [1:0][15:0] aux_ff;
  logic [1:0][15:0] line_one_ff;
  logic [1:0][15:0] line_two_ff;
  logic [1:0][15:0] dc_level;
  logic host_ident_wr;
  logic filter_clear;
  logic mode_known;
  logic signed [15:0] nxt_ident_acc;
  logic signed [16:0] ident_diff;

  // ----------------------------------------
  // Identification mode register
  // ----------------------------------------
  // Only the low byte belongs here; the high byte is a separate item
  assign host_ident_wr = reg_wr && (reg_addr == ident_dc_pkg::ADDR_IDENT_MODE);

  // Host write wins over the hardware update in the same cycle, so the filter
  // reset sequence is never lost to an automatic refresh.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ident_mode_ff <= ident_dc_pkg::IDENT_MODE_RESET;
    end else if (ce) begin
      if (host_ident_wr) begin
        ident_mode_ff <= reg_wdata[7:0];
      end else if (std_load) begin
        ident_mode_ff <= std_ident_code;
      end else if (auto_sound_select) begin
        ident_mode_ff <= auto_ident_code;
      end
    end
  end

  assign mode_known = (ident_mode_ff == ident_dc_pkg::IDENT_GERMAN) ||
                      (ident_mode_ff == ident_dc_pkg::IDENT_KOREAN);
  assign filter_clear = (ident_mode_ff == ident_dc_pkg::IDENT_FILTER_CLEAR);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      korean_ff <= 1'b0;
      active_ff <= 1'b0;
    end else if (ce) begin
      korean_ff <= (ident_mode_ff == ident_dc_pkg::IDENT_KOREAN);
      active_ff <= mode_known;
    end
  end

  // ----------------------------------------
  // Identification filter
  // ----------------------------------------
  // Settles in a few hundred ms; a clear skips the slow decay after a program change
  // Step kept at 17 bits, so a full-swing change cannot wrap
  always_comb begin
    ident_diff = 17'($signed({ident_sample, 8'h00})) - 17'(ident_acc_ff);
    nxt_ident_acc = ident_acc_ff + 16'(ident_diff >>> ident_dc_pkg::IDENT_SHIFT);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ident_acc_ff <= '0;
    end else if (ce) begin
      if (filter_clear || !mode_known) begin
        ident_acc_ff <= '0;
      end else if (ident_valid) begin
        ident_acc_ff <= nxt_ident_acc;
      end
    end
  end

  // ----------------------------------------
  // Carrier DC trackers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_carrier
      dc_track_if trk ();
      assign trk.sample_valid = fm_valid[gi];
      assign trk.sample = fm_sample[gi];
      assign dc_level[gi] = trk.dc_level;
      assign carrier_audio[gi] = trk.audio;

      dc_tracker u_dc (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .trk(trk)
      );
    end
  endgenerate

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Writes to the read-only words decode to nothing, so they leave them untouched
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= ident_dc_pkg::WORD_ZERO;
      rvalid_ff <= 1'b0;
    end else if (ce) begin
      rvalid_ff <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          ident_dc_pkg::ADDR_IDENT_MODE: rdata_ff <= {8'h00, ident_mode_ff};
          ident_dc_pkg::ADDR_STEREO_DETECT: rdata_ff <= {ident_acc_ff[15:8], 8'h00};
          ident_dc_pkg::ADDR_DC_ONE: rdata_ff <= dc_level[0];
          ident_dc_pkg::ADDR_DC_TWO: rdata_ff <= dc_level[1];
          default: rdata_ff <= ident_dc_pkg::WORD_ZERO;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // ----------------------------------------
  // Source routing
  // ----------------------------------------
  always_comb begin
    routed = '0;
    case (chan_select)
      ident_dc_pkg::SEL_FMAM: begin
        routed = fmam_in;
      end
      ident_dc_pkg::SEL_STEREO_AB: begin
        if (digital_std && !digital_ok) begin
          // Missing digital sound: silence unless FM fallback supplies analog mono
          routed = digital_sound_fm_fallback ? {analog_mono, analog_mono} : '0;
        end else begin
          routed = stereo_ab_in;
        end
      end
      ident_dc_pkg::SEL_STEREO_OR_ONE: begin
        if (sat_std) begin
          routed = stereo_mode ? stereo_ab_in : {carrier_audio[0], carrier_audio[0]};
        end
      end
      ident_dc_pkg::SEL_STEREO_OR_TWO: begin
        if (sat_std) begin
          routed = stereo_mode ? stereo_ab_in : {carrier_audio[1], carrier_audio[1]};
        end
      end
      default: begin
        routed = '0;
      end
    endcase
  end

  // ----------------------------------------
  // Output polarity
  // ----------------------------------------
  // Negating full scale would wrap, so line one saturates at the top instead
  function automatic logic [15:0] neg_sat(input logic [15:0] v);
    logic [15:0] r;
    r = (v == ident_dc_pkg::AUDIO_MIN) ? ident_dc_pkg::AUDIO_MAX : 16'(-v);
    return r;
  endfunction

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      main_ff <= '0;
      aux_ff <= '0;
      line_one_ff <= '0;
      line_two_ff <= '0;
    end else if (ce) begin
      main_ff <= routed;
      aux_ff <= routed;
      line_two_ff <= routed;
      line_one_ff <= {neg_sat(routed[1]), neg_sat(routed[0])};
    end
  end

  assign main_out = main_ff;
  assign aux_out = aux_ff;
  assign line_output_one = line_one_ff;
  assign line_output_two = line_two_ff;

  // ----------------------------------------
  // FM matrix override
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      matrix_ff <= 1'b0;
    end else if (ce) begin
      matrix_ff <= digital_std;
    end
  end

  assign fm_matrix_sound_a = matrix_ff;
  assign ident_korean = korean_ff;
  assign ident_active = active_ff;

endmodule

`default_nettype wire

// ==== tb/ident_dc_asserts.sv ====
/*
  Concurrent checks on the ports of the ident mode and DC readout block.
  Assumes a bind to stereo_ident_dc_regs, one clock domain and ce held high.
*/
`default_nettype none
module ident_dc_asserts (
  input wire logic clk_sys, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic [15:0] reg_addr, // Word address
  input wire logic [15:0] reg_wdata, // Write word
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [15:0] reg_rdata, // Read word
  input wire logic reg_rvalid, // Read valid
  input wire logic std_load, // Standard load
  input wire logic [7:0] std_ident_code, // Standard ident code
  input wire logic auto_sound_select, // Auto select
  input wire logic ident_korean, // Korean mode
  input wire logic ident_active, // Ident running
  input wire logic [2:0] chan_select, // Source select
  input wire logic digital_std, // Digital standard
  input wire logic [1:0][15:0] fmam_in, // FM/AM path
  input wire logic fm_matrix_sound_a, // Matrix force
  input wire logic [1:0][15:0] main_out, // Main output
  input wire logic [1:0][15:0] aux_out, // Aux output
  input wire logic [1:0][15:0] line_output_one, // Line output one
  input wire logic [1:0][15:0] line_output_two // Line output two
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic rd_take;
  logic wr_mode;
  logic unmapped;
  logic [7:0] code;
  logic [15:0] neg0;
  assign rd_take = ce && reg_rd;
  assign wr_mode = ce && reg_wr && reg_addr == ident_dc_pkg::ADDR_IDENT_MODE;
  assign code = reg_wdata[7:0];
  assign unmapped = !(reg_addr inside {16'h0015, 16'h0018, 16'h001b, 16'h001c});
  // The most negative word has no positive twin, so it saturates
  assign neg0 = (line_output_two[0] == 16'h8000) ? 16'h7fff : 16'h0000 - line_output_two[0];
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  read_answer_a: assert property (rd_take |=> reg_rvalid)
    else $error("read not answered");
  read_cause_a: assert property (reg_rvalid |-> $past(rd_take))
    else $error("read valid without read");
  unmapped_zero_a: assert property (rd_take && unmapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  mode_high_a: assert property (rd_take && reg_addr == 16'h0015 |=> reg_rdata[15:8] == 8'h00)
    else $error("mode read high byte set");
  level_low_a: assert property (rd_take && reg_addr == 16'h0018 |=> reg_rdata[7:0] == 8'h00)
    else $error("level read low byte set");
  korean_mode_a: assert property (wr_mode && code == ident_dc_pkg::IDENT_KOREAN |-> ##2 ident_korean && ident_active)
    else $error("korean mode not taken");
  german_mode_a: assert property (wr_mode && code == ident_dc_pkg::IDENT_GERMAN |-> ##2 !ident_korean && ident_active)
    else $error("german mode not taken");
  filter_clear_a: assert property (wr_mode && code == ident_dc_pkg::IDENT_FILTER_CLEAR |-> ##2 !ident_active)
    else $error("filter clear left ident running");
  reserved_code_a: assert property (wr_mode && !(code inside {8'h00, 8'h01, 8'h3f}) |-> ##2 !ident_active && !ident_korean)
    else $error("reserved code selected ident");
  std_load_a: assert property (ce && std_load && !reg_wr && !auto_sound_select && std_ident_code == 8'h01 |-> ##2 ident_korean)
    else $error("standard load ignored");
  matrix_force_a: assert property (ce |=> fm_matrix_sound_a == $past(digital_std))
    else $error("matrix force wrong");
  fmam_route_a: assert property (ce && chan_select == ident_dc_pkg::SEL_FMAM |=> main_out == $past(fmam_in))
    else $error("fm am route wrong");
  out_phase_a: assert property (line_output_one[0] == neg0 && aux_out == main_out && line_output_two == main_out)
    else $error("output phase wrong");
  cover property (wr_mode && code == ident_dc_pkg::IDENT_FILTER_CLEAR);
  cover property (rd_take && reg_addr == ident_dc_pkg::ADDR_DC_TWO);
  cover property (ce && chan_select == ident_dc_pkg::SEL_STEREO_OR_TWO);
endmodule

bind stereo_ident_dc_regs ident_dc_asserts u_ident_dc_asserts (
  .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .std_load(std_load),
  .std_ident_code(std_ident_code), .auto_sound_select(auto_sound_select), .ident_korean(ident_korean),
  .ident_active(ident_active), .chan_select(chan_select), .digital_std(digital_std), .fmam_in(fmam_in),
  .fm_matrix_sound_a(fm_matrix_sound_a), .main_out(main_out), .aux_out(aux_out),
  .line_output_one(line_output_one), .line_output_two(line_output_two));
`default_nettype wire

// ==== tb/i2c_host_model.sv ====
/*
  Host controller model: issues whole-word register transfers.
  Assumes the block takes a request on the rising edge where its strobe is high.
*/
`default_nettype none
module i2c_host_model #(
  parameter int SETTLE_CYC = 200
) (
  input wire logic clk_sys, // Clock
  output logic [15:0] reg_addr, // Word address
  output logic [15:0] reg_wdata, // Write word
  output logic reg_wr, // Write strobe
  output logic reg_rd // Read strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  // Released address and data lines show the inverse so a stale value is never mistaken for a hold
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_rd = rd;
    reg_wr = !rd;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Settle time shortened from half a second to keep the run short
  task automatic ident_restart(input logic [7:0] mode);
    xfer(1'b0, ident_dc_pkg::ADDR_IDENT_MODE, {8'h00, ident_dc_pkg::IDENT_FILTER_CLEAR});
    xfer(1'b0, ident_dc_pkg::ADDR_IDENT_MODE, {8'h00, mode});
    repeat (SETTLE_CYC) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== tb/stereo_ident_dc_regs_test.sv ====
/*
  Self-checking bench for stereo_ident_dc_regs.
  Assumes the host model and the bound checker are compiled alongside.
*/
`default_nettype none
module stereo_ident_dc_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic std_load = 1'b0;
  logic auto_sound_select = 1'b0;
  logic ident_valid = 1'b0;
  logic sat_std = 1'b0;
  logic stereo_mode = 1'b0;
  logic digital_std = 1'b0;
  logic digital_ok = 1'b0;
  logic digital_sound_fm_fallback = 1'b0;
  logic [2:0] chan_select = 3'h0;
  logic [7:0] std_ident_code = 8'h00;
  logic [7:0] auto_ident_code = 8'h00;
  logic [7:0] ident_sample = 8'h00;
  logic [1:0] fm_valid = 2'b00;
  logic [15:0] analog_mono = 16'h0000;
  logic [1:0][15:0] fm_sample = '0;
  logic [1:0][15:0] fmam_in = '0;
  logic [1:0][15:0] stereo_ab_in = '0;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, ident_korean, ident_active, fm_matrix_sound_a;
  logic [1:0][15:0] carrier_audio, main_out, aux_out, line_output_one, line_output_two;
  logic [15:0] exp_q[$], msk_q[$];
  int n_errors = 0;
  int num_checks = 0;
  // Each entry: select, satellite, stereo, digital, digital ok, fallback
  logic [7:0] cases [10] = '{8'h00, 8'h20, 8'h24, 8'h25, 8'h78, 8'h98, 8'h68, 8'h26, 8'h70, 8'h90};
  logic [7:0] rsv [4] = '{8'h02, 8'h3e, 8'h40, 8'hff};

  always #20 clk_sys = ~clk_sys;

  i2c_host_model u_i2c_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  stereo_ident_dc_regs u_stereo_ident_dc_regs (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .std_load(std_load), .std_ident_code(std_ident_code), .auto_sound_select(auto_sound_select),
    .auto_ident_code(auto_ident_code), .ident_valid(ident_valid), .ident_sample(ident_sample),
    .ident_korean(ident_korean), .ident_active(ident_active), .fm_valid(fm_valid), .fm_sample(fm_sample),
    .carrier_audio(carrier_audio), .chan_select(chan_select), .sat_std(sat_std), .stereo_mode(stereo_mode),
    .digital_std(digital_std), .digital_ok(digital_ok), .digital_sound_fm_fallback(digital_sound_fm_fallback),
    .fmam_in(fmam_in), .stereo_ab_in(stereo_ab_in), .analog_mono(analog_mono),
    .fm_matrix_sound_a(fm_matrix_sound_a), .main_out(main_out), .aux_out(aux_out),
    .line_output_one(line_output_one), .line_output_two(line_output_two));

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(negedge clk_sys) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) check(reg_rdata, 16'hxxxx, "unexpected read word");
      else check(reg_rdata & msk_q.pop_front(), exp_q.pop_front(), "read word");
    end
  end

  task automatic rd(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
    exp_q.push_back(e);
    msk_q.push_back(m);
    u_i2c_host_model.xfer(1'b1, a, 16'h0000);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    u_i2c_host_model.xfer(1'b0, a, d);
  endtask

  task automatic flags(input logic act, input logic kor);
    repeat (2) @(posedge clk_sys);
    #1;
    check({14'h0000, ident_active, ident_korean}, {14'h0000, act, kor}, "ident flags");
  endtask

  function automatic logic [15:0] route(input int c);
    if (chan_select == 3'h0) return fmam_in[c];
    if (chan_select == 3'h1 && digital_std && !digital_ok) return digital_sound_fm_fallback ? analog_mono : 16'h0000;
    if (chan_select == 3'h1) return stereo_ab_in[c];
    if ((chan_select == 3'h3 || chan_select == 3'h4) && sat_std && stereo_mode) return stereo_ab_in[c];
    if ((chan_select == 3'h3 || chan_select == 3'h4) && sat_std) return carrier_audio[chan_select == 3'h4];
    return 16'h0000;
  endfunction

  task automatic route_chk;
    logic [15:0] e;
    for (int c = 0; c < 2; c++) begin
      e = route(c);
      check(main_out[c], e, "main output");
      check(aux_out[c], e, "aux output");
      check(line_output_two[c], e, "line two output");
      check(line_output_one[c], (e == 16'h8000) ? 16'h7fff : 16'h0000 - e, "line one output");
    end
    check({15'h0000, fm_matrix_sound_a}, {15'h0000, digital_std}, "matrix force");
  endtask

  always @(posedge clk_sys) begin
    #1;
    ident_valid = 1'($urandom);
    ident_sample = 8'($urandom);
  end

  initial begin
    #2000000;
    check(16'h0000, 16'h0001, "run did not finish");
    wrap_up();
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h1f23_4c11));
    repeat (8) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    rd(16'h0015, 16'hffff, 16'h0000);
    flags(1'b1, 1'b0);
    wr(16'h0015, 16'hab01);
    flags(1'b1, 1'b1);
    rd(16'h0015, 16'hffff, 16'h0001);
    wr(16'h0015, 16'h003f);
    flags(1'b0, 1'b0);
    rd(16'h0018, 16'hffff, 16'h0000);
    wr(16'h0018, 16'h7f7f);
    rd(16'h0018, 16'hffff, 16'h0000);
    u_i2c_host_model.ident_restart(ident_dc_pkg::IDENT_GERMAN);
    rd(16'h0018, 16'h00ff, 16'h0000);
    flags(1'b1, 1'b0);
    foreach (rsv[i]) begin
      wr(16'h0015, {8'h00, rsv[i]});
      flags(1'b0, 1'b0);
    end
    std_ident_code = 8'h01;
    std_load = 1'b1;
    @(posedge clk_sys);
    #1;
    std_load = 1'b0;
    flags(1'b1, 1'b1);
    auto_sound_select = 1'b1;
    flags(1'b1, 1'b0);
    auto_sound_select = 1'b0;
    fm_sample = {16'he000, 16'h2000};
    fm_valid = 2'b11;
    repeat (3000) @(posedge clk_sys);
    #1;
    fm_valid = 2'b00;
    check({carrier_audio[0][15:8], carrier_audio[1][15:8]} & 16'hf0f0, 16'h00f0, "dc-free audio");
    rd(16'h001b, 16'hf000, 16'h1000);
    rd(16'h001c, 16'hf000, 16'he000);
    wr(16'h001c, 16'h0000);
    rd(16'h001c, 16'hf000, 16'he000);
    rd(16'h0077, 16'hffff, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      {chan_select, sat_std, stereo_mode, digital_std, digital_ok, digital_sound_fm_fallback} = cases[i];
      fmam_in = {16'($urandom), 16'($urandom)};
      stereo_ab_in = {16'($urandom), 16'($urandom)};
      analog_mono = 16'($urandom);
      if (i == 0) fmam_in[0] = 16'h8000;
      repeat (2) @(posedge clk_sys);
      #1;
      route_chk();
    end
    for (int k = 0; k < 50 && exp_q.size() > 0; k++) @(posedge clk_sys);
    if (exp_q.size() > 0) check(16'h0000, 16'h0001, "read left unanswered");
    wrap_up();
  end
endmodule
`default_nettype wire
